// *** verilog/fbep_pkg.sv ***
// Purpose: shared constants and types of the flash register link
// Assumes: one serial link, mode 0, msb first, 8-bit bytes
// Notes:   host registers sit on byte addresses of an Avalon-MM slave
package fbep_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 25;
  localparam int SCK_PERIOD_NS   = 400;
  localparam int SCK_HALF_CYCLES = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // link opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_REG   = 8'h01;
  localparam logic [7:0] OP_BANK_READ   = 8'h16;
  localparam logic [7:0] OP_BANK_WRITE  = 8'h17;
  localparam logic [7:0] OP_ECC_READ    = 8'h18;
  localparam logic [7:0] OP_PROT_READ   = 8'h2B;
  localparam logic [7:0] OP_PROT_PROG   = 8'h2F;
  localparam logic [7:0] OP_BANK_ACCESS = 8'hB9;

  // ---------------------------------------------------------------
  // bank extension register
  // ---------------------------------------------------------------
  localparam int         BANK_EXT_BIT   = 7;
  localparam int         BANK_HIGH_BIT  = 1;
  localparam int         BANK_LOW_BIT   = 0;
  localparam logic       BANK_EXT_RESET = 1'h0;
  localparam logic [1:0] BANK_RESET     = 2'h0;
  localparam logic [4:0] BANK_RSVD      = 5'h00;
  localparam logic [1:0] WRITE_REG_BANK_IDX = 2'h2;

  // ---------------------------------------------------------------
  // correction status
  // ---------------------------------------------------------------
  localparam int         ECC_CHECK_BIT  = 2;
  localparam int         ECC_DATA_BIT   = 1;
  localparam int         ECC_DIS_BIT    = 0;
  localparam int         ECC_UNIT_BYTES = 16;
  localparam int         ECC_UNIT_LSB   = $clog2(ECC_UNIT_BYTES);
  localparam int         ECC_IDX_W      = 4;
  localparam int         ECC_UNITS      = 16;
  localparam logic [2:0] ECC_RESET      = 3'h0;

  // ---------------------------------------------------------------
  // protection mode config
  // ---------------------------------------------------------------
  localparam int          PROT_PWD_BIT = 2;
  localparam int          PROT_PST_BIT = 1;
  localparam logic [15:0] PROT_RESET   = 16'hFFFF;

  // ---------------------------------------------------------------
  // host registers
  // ---------------------------------------------------------------
  localparam logic [4:0] CTRL_OFS   = 5'h00;
  localparam logic [4:0] ADDR_OFS   = 5'h04;
  localparam logic [4:0] WDATA_OFS  = 5'h08;
  localparam logic [4:0] RDATA_OFS  = 5'h0C;
  localparam logic [4:0] STAT_OFS   = 5'h10;
  localparam int         CTRL_NA_LSB = 8;
  localparam int         CTRL_NW_LSB = 11;
  localparam int         CTRL_NR_LSB = 14;
  localparam int         STAT_BUSY_BIT = 0;

  typedef enum logic [1:0] {D_CMD, D_ADDR, D_DATA, D_IGNORE}
    fbep_dev_state_type;
  typedef enum logic [1:0] {H_IDLE, H_RUN, H_END, H_GAP}
    fbep_host_state_type;
endpackage

// *** verilog/fbep_link_if.sv ***
// Purpose: serial link between host controller and flash register end
// Assumes: host makes the serial clock
// Notes:   all wires are one-way
`timescale 1ns/100ps
interface fbep_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;

  modport device (input sck, input cs_n, input mosi, output miso);
  modport host   (output sck, output cs_n, output mosi, input miso);
endinterface // fbep_link_if

// *** verilog/fbep_sync.sv ***
// Purpose: two-flop synchroniser for one link pin
// Assumes: input is asynchronous to core_clk
// Notes:   first flop feeds only the second
`timescale 1ns/100ps
module fbep_sync (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic pin,
  output logic      q
);
  logic meta_reg;

  // two stage capture
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end else begin
      meta_reg <= pin;
      q        <= meta_reg;
    end
  end
endmodule // fbep_sync

// *** verilog/fbep_flash_end.sv ***
// Purpose: flash side register group behind the serial link
// Assumes: mode 0 link, msb first, host holds cs_n low per command
// Notes:   srst models power-up; soft_reset models hw or sw reset
`timescale 1ns/100ps
module fbep_flash_end
  import fbep_pkg::*;
#(
  parameter logic [15:0] PROT_DEFAULT = PROT_RESET
) (
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  fbep_link_if.device               link,
  input  wire logic                 soft_reset,
  input  wire logic                 ecc_set_valid,
  input  wire logic [ECC_IDX_W-1:0] ecc_set_unit,
  input  wire logic [2:0]           ecc_set_bits,
  output logic                      extended_address_enable,
  output logic                      bank_high_bit,
  output logic                      bank_low_bit,
  output logic                      password_mode_lock,
  output logic                      persistent_mode_lock,
  output logic                      program_error,
  output logic [31:0]               last_address
);
  logic               sck_s, cs_n_s, mosi_s, sck_d_reg;
  logic               rise, fall, byte_done;
  logic [2:0]         bit_cnt_reg;
  logic [6:0]         rx_sh_reg;
  logic [7:0]         rx_byte, resp_byte, tx_reg, opcode_reg;
  logic [7:0]         prot_low_reg;
  logic [1:0]         addr_cnt_reg, data_idx_reg;
  logic [23:0]        addr_sh_reg;
  logic [31:0]        addr_full, addr_eff;
  logic [15:0]        prot_reg, prot_cand;
  logic [4:0]         noise_reg;
  logic [2:0]         ecc_table [ECC_UNITS];
  logic [ECC_IDX_W-1:0] unit_sel;
  logic               miso_reg;
  fbep_dev_state_type state_reg;

  // ---------------------------------------------------------------
  // link sampling
  // ---------------------------------------------------------------
  fbep_sync u_sck  (.core_clk(core_clk), .srst(srst),
                    .pin(link.sck),  .q(sck_s));
  fbep_sync u_cs   (.core_clk(core_clk), .srst(srst),
                    .pin(link.cs_n), .q(cs_n_s));
  fbep_sync u_mosi (.core_clk(core_clk), .srst(srst),
                    .pin(link.mosi), .q(mosi_s));

  // edge finder on the synchronised clock
  always_ff @(posedge core_clk) begin
    if (srst) sck_d_reg <= 1'b0;
    else      sck_d_reg <= sck_s;
  end

  assign rise      = sck_s & ~sck_d_reg & ~cs_n_s;
  assign fall      = ~sck_s & sck_d_reg & ~cs_n_s;
  assign byte_done = rise & (bit_cnt_reg == 3'h7);
  assign rx_byte   = {rx_sh_reg, mosi_s};

  // bit capture, restarted while deselected
  always_ff @(posedge core_clk) begin
    if (srst || cs_n_s) begin
      bit_cnt_reg <= 3'h0;
      rx_sh_reg   <= 7'h00;
    end else if (rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      rx_sh_reg   <= rx_byte[6:0];
    end
  end

  // ---------------------------------------------------------------
  // address forming
  // ---------------------------------------------------------------
  assign addr_full = {addr_sh_reg, rx_byte};
  assign addr_eff = extended_address_enable ? addr_full :
                    {6'h00, bank_high_bit, bank_low_bit, addr_full[23:0]};
  assign unit_sel = addr_eff[ECC_UNIT_LSB +: ECC_IDX_W];

  // ---------------------------------------------------------------
  // command sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst || cs_n_s) begin
      state_reg    <= D_CMD;
      opcode_reg   <= 8'h00;
      addr_cnt_reg <= 2'h0;
      data_idx_reg <= 2'h0;
      addr_sh_reg  <= 24'h000000;
    end else if (byte_done) begin
      case (state_reg)
        D_CMD: begin
          opcode_reg <= rx_byte;
          if (rx_byte == OP_ECC_READ) begin
            state_reg <= D_ADDR;
            addr_cnt_reg <= extended_address_enable ? 2'h3 : 2'h2;
          end else if (rx_byte == OP_BANK_READ ||
                       rx_byte == OP_BANK_WRITE ||
                       rx_byte == OP_BANK_ACCESS ||
                       rx_byte == OP_WRITE_REG ||
                       rx_byte == OP_PROT_READ ||
                       rx_byte == OP_PROT_PROG) begin
            state_reg <= D_DATA;
          end else begin
            state_reg <= D_IGNORE;
          end
        end
        D_ADDR: begin
          addr_sh_reg  <= addr_full[23:0];
          addr_cnt_reg <= addr_cnt_reg - 2'h1;
          if (addr_cnt_reg == 2'h0) state_reg <= D_DATA;
        end
        D_DATA: begin
          if (data_idx_reg != 2'h3) data_idx_reg <= data_idx_reg + 2'h1;
        end
        default: ;
      endcase
    end
  end

  // address of the latest status read
  always_ff @(posedge core_clk) begin
    if (srst) last_address <= 32'h00000000;
    else if (byte_done && state_reg == D_ADDR && addr_cnt_reg == 2'h0)
      last_address <= addr_eff;
  end

  // ---------------------------------------------------------------
  // bank extension register
  // ---------------------------------------------------------------
  // cleared on every reset
  always_ff @(posedge core_clk) begin
    if (srst || soft_reset) begin
      extended_address_enable <= BANK_EXT_RESET;
      {bank_high_bit, bank_low_bit} <= BANK_RESET;
    end else if (byte_done && state_reg == D_DATA &&
                 (((opcode_reg == OP_BANK_WRITE ||
                    opcode_reg == OP_BANK_ACCESS) &&
                   data_idx_reg == 2'h0) ||
                  (opcode_reg == OP_WRITE_REG &&
                   data_idx_reg == WRITE_REG_BANK_IDX))) begin
      extended_address_enable <= rx_byte[BANK_EXT_BIT];
      bank_high_bit           <= rx_byte[BANK_HIGH_BIT];
      bank_low_bit            <= rx_byte[BANK_LOW_BIT];
    end
  end

  // ---------------------------------------------------------------
  // correction status table
  // ---------------------------------------------------------------
  // hardware set, zero default; a set beats a soft reset
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < ECC_UNITS; i++) begin
      if (srst || soft_reset) ecc_table[i] <= ECC_RESET;
    end
    if (!srst && ecc_set_valid) ecc_table[ecc_set_unit] <= ecc_set_bits;
  end

  always_ff @(posedge core_clk) begin
    if (srst) noise_reg <= 5'h00;
    else if (byte_done && state_reg == D_ADDR) noise_reg <= noise_reg + 5'h03;
  end

  // ---------------------------------------------------------------
  // protection mode config
  // ---------------------------------------------------------------
  // program only clears bits
  assign prot_cand = prot_reg & {rx_byte, prot_low_reg};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      prot_reg      <= PROT_DEFAULT;
      prot_low_reg  <= 8'hFF;
      program_error <= 1'b0;
    end else if (soft_reset) begin
      program_error <= 1'b0;
    end else if (byte_done && state_reg == D_DATA &&
                 opcode_reg == OP_PROT_PROG) begin
      if (data_idx_reg == 2'h0) begin
        prot_low_reg <= rx_byte;
      end else if (data_idx_reg == 2'h1) begin
        if (!prot_cand[PROT_PWD_BIT] && !prot_cand[PROT_PST_BIT]) begin
          program_error <= 1'b1;
        end else begin
          prot_reg      <= prot_cand;
          program_error <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      password_mode_lock   <= 1'b0;
      persistent_mode_lock <= 1'b0;
    end else begin
      password_mode_lock   <= ~prot_reg[PROT_PWD_BIT];
      persistent_mode_lock <= ~prot_reg[PROT_PST_BIT];
    end
  end

  // ---------------------------------------------------------------
  // response path
  // ---------------------------------------------------------------
  // next byte to shift out after the byte just taken
  always_comb begin
    resp_byte = 8'h00;
    case (state_reg)
      D_CMD: begin
        if (rx_byte == OP_BANK_READ) begin
          resp_byte = {extended_address_enable, BANK_RSVD,
                       bank_high_bit, bank_low_bit};
        end else if (rx_byte == OP_PROT_READ) begin
          resp_byte = prot_reg[7:0];
        end
      end
      D_ADDR: begin
        if (addr_cnt_reg == 2'h0) resp_byte = {noise_reg, ecc_table[unit_sel]};
      end
      D_DATA: begin
        if (opcode_reg == OP_PROT_READ && data_idx_reg == 2'h0) begin
          resp_byte = prot_reg[15:8];
        end
      end
      default: ;
    endcase
  end

  // load on byte end, shift on each falling edge
  always_ff @(posedge core_clk) begin
    if (srst || cs_n_s) begin
      tx_reg   <= 8'h00;
      miso_reg <= 1'b0;
    end else if (byte_done) begin
      tx_reg <= resp_byte;
    end else if (fall) begin
      miso_reg <= tx_reg[7];
      tx_reg   <= {tx_reg[6:0], 1'b0};
    end
  end

  assign link.miso = miso_reg;
endmodule // fbep_flash_end

// *** verilog/fbep_host_end.sv ***
// Purpose: link host controller, driven from Avalon-MM registers
// Assumes: one frame at a time; writes to CTRL start it
// Notes:   frame = opcode, address msb first, write then read bytes
`timescale 1ns/100ps
module fbep_host_end
  import fbep_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  fbep_link_if.host        link,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  logic [16:0]         ctrl_reg;
  logic [31:0]         addr_reg, wdata_reg, rdata_reg;
  logic                miso_s, start, take_wr;
  logic [3:0]          cnt_reg, byte_idx_reg, total;
  logic [2:0]          bit_cnt_reg, na, nw, nr;
  logic [7:0]          tx_sh_reg, next_byte, rx_byte;
  logic [6:0]          rx_sh_reg;
  logic                sck_reg, cs_n_reg, mosi_reg;
  fbep_host_state_type state_reg;

  // frame byte for an index
  function automatic logic [7:0] frame_byte(
    input logic [3:0]  idx,
    input logic [7:0]  op,
    input logic [2:0]  an,
    input logic [2:0]  wn,
    input logic [31:0] ad,
    input logic [31:0] wd
  );
    logic [3:0] k;
    k = 4'h0;
    if (idx == 4'h0) begin
      return op;
    end else if (idx <= {1'b0, an}) begin
      k = {1'b0, an} - idx;
      return ad[{k[1:0], 3'b000} +: 8];
    end else if (idx <= {1'b0, an} + {1'b0, wn}) begin
      k = idx - {1'b0, an} - 4'h1;
      return wd[{k[1:0], 3'b000} +: 8];
    end
    return 8'h00;
  endfunction

  assign na      = ctrl_reg[CTRL_NA_LSB +: 3];
  assign nw      = ctrl_reg[CTRL_NW_LSB +: 3];
  assign nr      = ctrl_reg[CTRL_NR_LSB +: 3];
  assign total   = 4'h1 + {1'b0, na} + {1'b0, nw} + {1'b0, nr};
  assign take_wr = avs_write & ~avs_waitrequest;
  assign start   = take_wr & (avs_address == CTRL_OFS) &
                   (state_reg == H_IDLE);
  assign rx_byte = {rx_sh_reg, miso_s};
  assign next_byte = frame_byte(byte_idx_reg + 4'h1, ctrl_reg[7:0],
                                na, nw, addr_reg, wdata_reg);

  fbep_sync u_miso (.core_clk(core_clk), .srst(srst),
                    .pin(link.miso), .q(miso_s));

  // ---------------------------------------------------------------
  // Avalon-MM slave
  // ---------------------------------------------------------------
  // one wait cycle per access, then answer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      if (avs_address == CTRL_OFS) avs_readdata <= {15'h0000, ctrl_reg};
      else if (avs_address == ADDR_OFS) avs_readdata <= addr_reg;
      else if (avs_address == WDATA_OFS) avs_readdata <= wdata_reg;
      else if (avs_address == RDATA_OFS) avs_readdata <= rdata_reg;
      else if (avs_address == STAT_OFS)
        avs_readdata <= {31'h00000000, state_reg != H_IDLE};
      else avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // register writes; CTRL ignored while busy
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_reg  <= 17'h00000;
      addr_reg  <= 32'h00000000;
      wdata_reg <= 32'h00000000;
    end else if (take_wr) begin
      if (start) ctrl_reg <= avs_writedata[16:0];
      else if (avs_address == ADDR_OFS) addr_reg <= avs_writedata;
      else if (avs_address == WDATA_OFS) wdata_reg <= avs_writedata;
    end
  end

  // ---------------------------------------------------------------
  // link engine
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg    <= H_IDLE;
      sck_reg      <= 1'b0;
      cs_n_reg     <= 1'b1;
      mosi_reg     <= 1'b0;
      cnt_reg      <= 4'h0;
      bit_cnt_reg  <= 3'h0;
      byte_idx_reg <= 4'h0;
      tx_sh_reg    <= 8'h00;
      rx_sh_reg    <= 7'h00;
    end else begin
      case (state_reg)
        H_IDLE: begin
          cnt_reg <= 4'h0;
          if (start) begin
            state_reg    <= H_RUN;
            cs_n_reg     <= 1'b0;
            bit_cnt_reg  <= 3'h0;
            byte_idx_reg <= 4'h0;
            tx_sh_reg    <= avs_writedata[7:0];
            mosi_reg     <= avs_writedata[7];
          end
        end
        H_RUN: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == 4'(SCK_HALF_CYCLES - 1)) begin
            cnt_reg <= 4'h0;
            if (!sck_reg) begin
              sck_reg   <= 1'b1;
              rx_sh_reg <= rx_byte[6:0];
            end else begin
              sck_reg <= 1'b0;
              if (bit_cnt_reg == 3'h7) begin
                bit_cnt_reg <= 3'h0;
                if (byte_idx_reg == total - 4'h1) begin
                  state_reg <= H_END;
                  mosi_reg  <= 1'b0;
                end else begin
                  byte_idx_reg <= byte_idx_reg + 4'h1;
                  tx_sh_reg    <= next_byte;
                  mosi_reg     <= next_byte[7];
                end
              end else begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                mosi_reg    <= tx_sh_reg[6];
                tx_sh_reg   <= {tx_sh_reg[6:0], 1'b0};
              end
            end
          end
        end
        H_END, H_GAP: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == 4'(SCK_HALF_CYCLES - 1)) begin
            cnt_reg   <= 4'h0;
            cs_n_reg  <= 1'b1;
            state_reg <= (state_reg == H_END) ? H_GAP : H_IDLE;
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  // read bytes stored low byte first
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_reg <= 32'h00000000;
    end else if (start) begin
      rdata_reg <= 32'h00000000;
    end else if (state_reg == H_RUN && !sck_reg && bit_cnt_reg == 3'h7 &&
                 cnt_reg == 4'(SCK_HALF_CYCLES - 1) &&
                 byte_idx_reg > {1'b0, na} + {1'b0, nw}) begin
      rdata_reg[{2'(byte_idx_reg - {1'b0, na} - {1'b0, nw} - 4'h1),
                 3'b000} +: 8] <= rx_byte;
    end
  end

  assign link.sck  = sck_reg;
  assign link.cs_n = cs_n_reg;
  assign link.mosi = mosi_reg;
endmodule // fbep_host_end

// *** sim/fbep_link_properties.sv ***
// Purpose: timing checks on the serial link between both ends
// Assumes: one core_clk domain, srst synchronous active high
// Notes:   watches link wires only
`timescale 1ns/100ps
module fbep_link_properties (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  // ---------------------------------------------------------------
  // link properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_miso_idle; cs_n |-> !miso; endproperty
  a_miso_idle: assert property (p_miso_idle)
    else $error("miso driven outside a frame");
  property p_sck_idle; cs_n |-> !sck; endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("sck moves outside a frame");
  property p_cs_gap; $rose(cs_n) |-> cs_n[*8]; endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("frame gap too short");
  property p_sck_high; $rose(sck) |-> sck[*6] ##[1:4] !sck; endproperty
  a_sck_high: assert property (p_sck_high)
    else $error("sck high phase wrong");
  property p_sck_low; $fell(sck) && !cs_n |-> (!sck)[*8]; endproperty
  a_sck_low: assert property (p_sck_low)
    else $error("sck low phase too short");
  property p_mosi_hold; !cs_n && sck |-> $stable(mosi); endproperty
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("mosi changes while sck high");
  property p_miso_hold; !cs_n && sck |-> $stable(miso); endproperty
  a_miso_hold: assert property (p_miso_hold)
    else $error("miso changes while sck high");
  property p_first_edge;
    $fell(cs_n) |-> (!sck)[*4] ##[1:12] sck;
  endproperty
  a_first_edge: assert property (p_first_edge)
    else $error("first sck edge out of place");
endmodule // fbep_link_properties

// *** sim/fbep_tb_top.sv ***
// Purpose: drives the host end over Avalon-MM, watches the flash end
// Assumes: both ends joined by one link interface
// Notes:   table rows first, reset and lock cases after
`timescale 1ns/100ps
module fbep_tb_top
  import fbep_pkg::*;
;
  typedef struct packed {
    logic [7:0] op; logic [2:0] na; logic [2:0] nw; logic [2:0] nr;
    logic [31:0] ad; logic [31:0] wd; logic [31:0] rd; logic [31:0] mk;
    logic [31:0] la; logic [5:0] fl;
  } fbep_row_type;
  logic core_clk = 1'b0, srst = 1'b1, soft_reset = 1'b0;
  logic avs_read = 1'b0, avs_write = 1'b0, ecc_set_valid = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, last_address;
  logic avs_waitrequest, ext, bhi, blo, pwd, pst, perr;
  logic [3:0] ecc_set_unit = 4'h0;
  logic [2:0] ecc_set_bits = 3'h0;
  logic [5:0] flags;
  int fail_count = 0, total_checks = 0;
  assign flags = {ext, bhi, blo, pwd, pst, perr};
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("FAIL %0t got %h want %h", $time, g, e); end end
  // ---------------------------------------------------------------
  // ordinary cases: op na nw nr addr wdata rdata mask last_addr flags
  // ---------------------------------------------------------------
  fbep_row_type rows [14] = '{
    '{OP_BANK_WRITE,3'h0,3'h1,3'h0,32'h0,32'h03,32'h0,32'h0,32'h0,6'h18},
    '{OP_BANK_READ,3'h0,3'h0,3'h1,32'h0,32'h0,32'h03,32'hFF,32'h0,6'h18},
    '{OP_BANK_ACCESS,3'h0,3'h1,3'h0,32'h0,32'hFD,32'h0,32'h0,32'h0,6'h28},
    '{OP_BANK_READ,3'h0,3'h0,3'h1,32'h0,32'h0,32'h81,32'hFF,32'h0,6'h28},
    '{OP_WRITE_REG,3'h0,3'h3,3'h0,32'h0,32'h2FFFF,32'h0,32'h0,32'h0,6'h10},
    '{OP_ECC_READ,3'h3,3'h0,3'h1,32'h50,32'h0,32'h6,32'h7,32'h2000050,
      6'h10},
    '{OP_BANK_WRITE,3'h0,3'h1,3'h0,32'h0,32'h80,32'h0,32'h0,32'h0,6'h20},
    '{OP_ECC_READ,3'h4,3'h0,3'h1,32'h12340060,32'h0,32'h1,32'h7,
      32'h12340060,6'h20},
    '{OP_PROT_READ,3'h0,3'h0,3'h2,32'h0,32'h0,32'hFFFF,32'hFFFF,32'h0,6'h20},
    '{OP_PROT_PROG,3'h0,3'h2,3'h0,32'h0,32'hFFFB,32'h0,32'h0,32'h0,6'h24},
    '{OP_PROT_PROG,3'h0,3'h2,3'h0,32'h0,32'hFFFD,32'h0,32'h0,32'h0,6'h25},
    '{OP_PROT_PROG,3'h0,3'h2,3'h0,32'h0,32'hFFFF,32'h0,32'h0,32'h0,6'h24},
    '{OP_PROT_READ,3'h0,3'h0,3'h2,32'h0,32'h0,32'hFFFB,32'hFFFF,32'h0,6'h24},
    '{8'h05,3'h0,3'h1,3'h1,32'h0,32'h03,32'h0,32'hFF,32'h0,6'h24}
  };
  fbep_link_if i_fbep_link_if ();
  fbep_host_end i_fbep_host_end (.core_clk(core_clk), .srst(srst),
    .link(i_fbep_link_if), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  fbep_flash_end i_fbep_flash_end (.core_clk(core_clk), .srst(srst),
    .link(i_fbep_link_if), .soft_reset(soft_reset),
    .ecc_set_valid(ecc_set_valid), .ecc_set_unit(ecc_set_unit),
    .ecc_set_bits(ecc_set_bits), .extended_address_enable(ext),
    .bank_high_bit(bhi), .bank_low_bit(blo), .password_mode_lock(pwd),
    .persistent_mode_lock(pst), .program_error(perr),
    .last_address(last_address));
  fbep_link_properties i_fbep_link_properties (.core_clk(core_clk),
    .srst(srst), .sck(i_fbep_link_if.sck), .cs_n(i_fbep_link_if.cs_n),
    .mosi(i_fbep_link_if.mosi), .miso(i_fbep_link_if.miso));
  always #12.5 core_clk = ~core_clk;
  task conclude;
    if (fail_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one Avalon-MM access, held until waitrequest is seen low
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
           output logic [31:0] q);
    int n;
    avs_address <= a; avs_writedata <= d;
    avs_write <= wr; avs_read <= !wr;
    n = 0;
    do begin @(posedge core_clk); n++; end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      fail_count++; $display("FAIL %0t bus timeout", $time); conclude();
    end
    q = avs_readdata;
    avs_write <= 1'b0; avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  // one link frame: load, start, poll busy, fetch read bytes
  task frame(input logic [7:0] op, input logic [2:0] na, nw, nr,
             input logic [31:0] ad, wd, output logic [31:0] q);
    int k;
    bus(1'b1, ADDR_OFS, ad, q);
    bus(1'b1, WDATA_OFS, wd, q);
    bus(1'b1, CTRL_OFS, {15'h0000, nr, nw, na, op}, q);
    k = 0;
    do begin bus(1'b0, STAT_OFS, 32'h0, q); k++; end
    while (q[STAT_BUSY_BIT] !== 1'b0 && k < 2000);
    if (k >= 2000) begin
      fail_count++; $display("FAIL %0t frame timeout", $time); conclude();
    end
    bus(1'b0, RDATA_OFS, 32'h0, q);
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    ecc_set_valid <= 1'b1; ecc_set_unit <= 4'h5; ecc_set_bits <= 3'h6;
    @(posedge core_clk);
    ecc_set_unit <= 4'h6; ecc_set_bits <= 3'h1;
    @(posedge core_clk);
    ecc_set_valid <= 1'b0;
    foreach (rows[i]) begin
      frame(rows[i].op, rows[i].na, rows[i].nw, rows[i].nr, rows[i].ad,
            rows[i].wd, rd);
      `CHK(rd & rows[i].mk, rows[i].rd)
      `CHK(flags, rows[i].fl)
      if (rows[i].op == OP_ECC_READ) `CHK(last_address, rows[i].la)
    end
    bus(1'b0, 5'h14, 32'h0, rd);
    `CHK(rd, 32'h0)
    // hardware reset clears bank and status, keeps one-time bits
    soft_reset <= 1'b1;
    @(posedge core_clk);
    soft_reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK(flags, 6'h04)
    frame(OP_ECC_READ, 3'h3, 3'h0, 3'h1, 32'h50, 32'h0, rd);
    `CHK(rd & 32'h7, 32'h0)
    // power-up reload, then the other lock
    srst <= 1'b1;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK(flags, 6'h00)
    frame(OP_PROT_PROG, 3'h0, 3'h2, 3'h0, 32'h0, 32'hFFFD, rd);
    `CHK(flags, 6'h02)
    frame(OP_PROT_READ, 3'h0, 3'h0, 3'h2, 32'h0, 32'h0, rd);
    `CHK(rd & 32'hFFFF, 32'hFFFD)
    conclude();
  end
endmodule // fbep_tb_top
